// file: hw/flash_page_erase_sequencer.sv
// APB-controlled page erase sequencer for an on-chip flash array
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module flash_page_erase_sequencer
   import flash_erase_pkg::*;
#(
   parameter logic [CNT_W-1:0] ERASE_SHORT_CYC = ERASE_SHORT_CYC_DEF,
   parameter logic [CNT_W-1:0] ERASE_LONG_CYC  = ERASE_LONG_CYC_DEF
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output var  logic [DATA_W-1:0] prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   // Flash array side
   output var  logic              eraseHv,
   output var  logic [8:0]        erasePage,
   output var  logic [1:0]        programRow
);
   // ==========================================
   // State
   seq_state_t       state;
   seq_state_t       next_state;
   logic [3:0]       ctrl;
   logic [7:0]       blockProtect;
   logic [3:0]       flags;
   logic [3:0]       next_flags;
   logic             pageLatched;
   logic             protRead;
   logic [CNT_W-1:0] stepCount;
   logic [DATA_W-1:0] readMux;
   logic             hitOk;

   // ==========================================
   // Bus decode
   wire accessWait = psel & penable & ~pready;
   wire done       = psel & penable & pready;
   wire arrayHit   = paddr[ARRAY_SEL_BIT];
   wire hitCtrl    = ~arrayHit & (paddr[15:0] == CTRL_OFF);
   wire hitProt    = ~arrayHit & (paddr[15:0] == PROTECT_OFF);
   wire hitStat    = ~arrayHit & (paddr[15:0] == STATUS_OFF);
   wire hitPage    = ~arrayHit & (paddr[15:0] == PAGE_OFF);
   // Array reads wait out the recovery time rather than return bad data
   wire stallRead  = arrayHit & ~pwrite & (state == ST_RECOV);
   wire answer     = accessWait & ~stallRead;
   wire ctrlWr     = done & pwrite & hitCtrl;
   wire protRd     = done & ~pwrite & hitProt;
   wire arrWr      = done & pwrite & arrayHit;
   wire statWr     = done & pwrite & hitStat;
   wire newErase   = pwdata[CTRL_ERASE_BIT];
   wire newMass    = pwdata[CTRL_MASS_BIT];
   wire newHv      = pwdata[CTRL_HV_BIT];
   wire hvOn       = ctrl[CTRL_HV_BIT];
   wire eraseDrop  = ctrlWr & ~newErase;
   wire [CNT_W-1:0] eraseMin = ctrl[CTRL_LONG_BIT] ? ERASE_LONG_CYC : ERASE_SHORT_CYC;
   wire hvState    = (next_state == ST_HV) | (next_state == ST_HOLD);
   wire [3:0] next_ctrl = ctrlWr ? pwdata[3:0] : ctrl;

   always_comb begin
      hitOk   = 1'b1;
      readMux = '0;
      if (arrayHit) begin
         readMux = '0;
      end else if (hitCtrl) begin
         readMux = {28'h0000000, ctrl};
      end else if (hitProt) begin
         readMux = {24'h000000, blockProtect};
      end else if (hitStat) begin
         readMux = {20'h00000, flags, 1'b0, eraseHv, protRead, pageLatched, 1'b0, state};
      end else if (hitPage) begin
         readMux = {21'h000000, programRow, erasePage};
      end else begin
         hitOk = 1'b0;
      end
   end

   // ==========================================
   // Sequencer
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (ctrlWr && newErase && !newMass) next_state = ST_MODE;
         end
         ST_MODE: begin
            if (eraseDrop) next_state = ST_IDLE;
            else if (protRd) next_state = ST_PROT;
         end
         ST_PROT: begin
            if (eraseDrop) next_state = ST_IDLE;
            else if (arrWr) next_state = ST_LATCH;
         end
         ST_LATCH: begin
            if (eraseDrop) next_state = ST_IDLE;
            else if (ctrlWr && newHv) next_state = ST_HV;
         end
         ST_HV: begin
            if (eraseDrop) next_state = ST_HOLD;
         end
         ST_HOLD: begin
            if (ctrlWr && !newHv) next_state = ST_RECOV;
         end
         ST_RECOV: begin
            if (stepCount >= RECOVERY_CYC) next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Setup, erase and hold breaches are flagged, not blocked: software owns those waits
   always_comb begin
      next_flags = flags & ~(statWr ? pwdata[STAT_FLAG_LSB +: 4] : 4'h0);
      if (state == ST_LATCH && ctrlWr && newErase && newHv && stepCount < SETUP_CYC)
         next_flags[FLAG_SETUP] = 1'b1;
      if (state == ST_HV && eraseDrop && stepCount < eraseMin)
         next_flags[FLAG_ERASE] = 1'b1;
      if (state == ST_HOLD && ctrlWr && !newHv && stepCount < HOLD_CYC)
         next_flags[FLAG_HOLD] = 1'b1;
      if (ctrlWr && newHv && !hvOn && state != ST_LATCH)
         next_flags[FLAG_ORDER] = 1'b1;
   end

   step_timer u_timer (
      .clk     (clk),
      .rst     (rst),
      .restart (next_state != state),
      .count   (stepCount)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         state        <= ST_IDLE;
         ctrl         <= CTRL_RESET;
         blockProtect <= PROTECT_RESET;
         flags        <= FLAGS_RESET;
         pageLatched  <= 1'b0;
         protRead     <= 1'b0;
         erasePage    <= PAGE_RESET;
         programRow   <= 2'b00;
         eraseHv      <= 1'b0;
      end else begin
         state    <= next_state;
         ctrl     <= next_ctrl;
         flags    <= next_flags;
         protRead <= (next_state != ST_IDLE) & (protRead | protRd);
         pageLatched <= (next_state == ST_LATCH) | hvState | (pageLatched & (next_state == ST_RECOV));
         if (done && pwrite && hitProt) blockProtect <= pwdata[7:0];
         if (state == ST_PROT && arrWr) begin
            erasePage  <= paddr[15:PAGE_LSB];
            programRow <= paddr[PAGE_LSB:ROW_LSB];
         end
         eraseHv <= hvState & next_ctrl[CTRL_HV_BIT];
      end
   end

   // ==========================================
   // APB answer, one wait state
   always_ff @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= answer;
         pslverr <= answer & ~hitOk;
         prdata  <= answer ? readMux : '0;
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_mode_entry: assert property (state == ST_IDLE && ctrlWr && newErase && !newMass |=> state == ST_MODE)
      else $error("erase select did not enter mode step");
   chk_mass_blocks: assert property (state == ST_IDLE && ctrlWr && newMass |=> state == ST_IDLE)
      else $error("whole-array bit did not block page erase");
   chk_prot_first: assert property (state == ST_MODE && arrWr |=> state == ST_MODE && !pageLatched)
      else $error("page latched before protect read");
   chk_page_latch: assert property (state == ST_PROT && arrWr |=>
                                    state == ST_LATCH && erasePage == $past(paddr[15:7]))
      else $error("page address not latched");
   chk_setup_flag: assert property (state == ST_LATCH && ctrlWr && newErase && newHv
                                    && stepCount < SETUP_CYC |=> flags[FLAG_SETUP])
      else $error("early high voltage not flagged");
   chk_erase_flag: assert property (state == ST_HV && eraseDrop && stepCount < eraseMin
                                    |=> flags[FLAG_ERASE] && state == ST_HOLD)
      else $error("short erase not flagged");
   chk_hold_flag: assert property (state == ST_HOLD && ctrlWr && !newHv && stepCount < HOLD_CYC
                                   |=> flags[FLAG_HOLD] && !eraseHv)
      else $error("short hold not flagged");
   chk_recov_stall: assert property (state == ST_RECOV && accessWait && arrayHit && !pwrite |=> !pready)
      else $error("array read answered during recovery");
   chk_recov_len: assert property (state == ST_RECOV && stepCount < RECOVERY_CYC |=> state == ST_RECOV)
      else $error("recovery ended early");
   chk_row_latch: assert property (state == ST_PROT && arrWr |=> programRow == $past(paddr[7:6]))
      else $error("row index not latched");
   chk_hv_gated: assert property (eraseHv |-> (state == ST_HV || state == ST_HOLD) && pageLatched && hvOn)
      else $error("high voltage without latched page");
   // Aborts, order breaches and error responses, the paths a clean erase never takes
   chk_abort_idle: assert property (state inside {ST_MODE, ST_PROT, ST_LATCH} && eraseDrop
                                    |=> state == ST_IDLE)
      else $error("erase clear did not abort");
   chk_order_flag: assert property (ctrlWr && newHv && !hvOn && state != ST_LATCH |=> flags[FLAG_ORDER])
      else $error("out-of-order high voltage not flagged");
   chk_err_pulse: assert property (pslverr |-> pready)
      else $error("error response without ready");

   cov_erase_on: cover property (state == ST_LATCH ##1 state == ST_HV);
   cov_full_pass: cover property (state == ST_RECOV ##1 state == ST_IDLE);
   cov_stall: cover property (stallRead && accessWait);
   cov_setup_breach: cover property ($rose(flags[FLAG_SETUP]));
   cov_mass_refused: cover property (state == ST_IDLE && ctrlWr && newMass);
endmodule : flash_page_erase_sequencer
`default_nettype wire

// file: shared/flash_erase_pkg.sv
// Constants, fields, timing and state encoding of the flash page erase sequencer
package flash_erase_pkg;
   // ==========================================
   // Bus and address map
   localparam int unsigned ADDR_W        = 17;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned ARRAY_SEL_BIT = 16;
   localparam logic [15:0] CTRL_OFF      = 16'h0000;
   localparam logic [15:0] PROTECT_OFF   = 16'h0004;
   localparam logic [15:0] STATUS_OFF    = 16'h0008;
   localparam logic [15:0] PAGE_OFF      = 16'h000c;
   // ==========================================
   // Fields and reset values
   localparam int unsigned CTRL_ERASE_BIT = 0;
   localparam int unsigned CTRL_MASS_BIT  = 1;
   localparam int unsigned CTRL_HV_BIT    = 2;
   localparam int unsigned CTRL_LONG_BIT  = 3;
   localparam logic [3:0]  CTRL_RESET     = 4'h0;
   localparam logic [7:0]  PROTECT_RESET  = 8'h00;
   localparam int unsigned STAT_LATCH_BIT = 4;
   localparam int unsigned STAT_PROT_BIT  = 5;
   localparam int unsigned STAT_HV_BIT    = 6;
   localparam int unsigned STAT_FLAG_LSB  = 8;
   localparam int unsigned FLAG_SETUP     = 0;
   localparam int unsigned FLAG_ERASE     = 1;
   localparam int unsigned FLAG_HOLD      = 2;
   localparam int unsigned FLAG_ORDER     = 3;
   localparam logic [3:0]  FLAGS_RESET    = 4'h0;
   localparam int unsigned PAGE_LSB       = 7;
   localparam int unsigned ROW_LSB        = 6;
   localparam logic [8:0]  PAGE_RESET     = 9'h000;
   // ==========================================
   // Timing, 5 ns clock; minimums round up
   localparam int unsigned CNT_W              = 20;
   localparam int unsigned CLK_PERIOD_NS      = 5;
   localparam int unsigned SETUP_BEFORE_HV_NS = 10000;
   localparam int unsigned ERASE_SHORT_NS     = 1000000;
   localparam int unsigned ERASE_LONG_NS      = 4000000;
   localparam int unsigned HOLD_AFTER_CLR_NS  = 5000;
   localparam int unsigned READ_RECOVERY_NS   = 1000;
   localparam logic [CNT_W-1:0] SETUP_CYC =
      CNT_W'((SETUP_BEFORE_HV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ERASE_SHORT_CYC_DEF =
      CNT_W'((ERASE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ERASE_LONG_CYC_DEF =
      CNT_W'((ERASE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] HOLD_CYC =
      CNT_W'((HOLD_AFTER_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RECOVERY_CYC =
      CNT_W'((READ_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // ==========================================
   // Sequencer states, Gray along the erase path from idle to recovery
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_MODE  = 3'b001,
      ST_PROT  = 3'b011,
      ST_LATCH = 3'b010,
      ST_HV    = 3'b110,
      ST_HOLD  = 3'b111,
      ST_RECOV = 3'b101
   } seq_state_t;
endpackage : flash_erase_pkg

// file: hw/step_timer.sv
// Saturating count of cycles spent in the current sequencer step
`timescale 1ns/1ps
`default_nettype none
module step_timer
   import flash_erase_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Control and count
   input  wire logic             restart,
   output var  logic [CNT_W-1:0] count
);
   // Starts at one so the count equals whole cycles elapsed in the step
   always_ff @(posedge clk) begin
      if (rst || restart) begin
         count <= CNT_W'(1);
      end else if (count != {CNT_W{1'b1}}) begin
         count <= count + CNT_W'(1);
      end
   end
endmodule : step_timer
`default_nettype wire

// file: dv/flash_array_model.sv
// Behavioural model of the flash array and its high-voltage circuit
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
   import flash_erase_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Erase control from the sequencer
   input  wire logic             eraseHv,
   input  wire logic [8:0]       erasePage,
   // Observation for the bench
   output var  logic [CNT_W-1:0] hvLen,
   output var  logic [8:0]       lastPage,
   output var  logic [7:0]       eraseCount
);
   // ==========================================
   // Erase pulse measurement
   logic [CNT_W-1:0] run;
   // A page is only erased when high voltage really arrives; a held page alone does nothing
   always_ff @(posedge clk) begin
      if (rst) begin
         run        <= '0;
         hvLen      <= '0;
         lastPage   <= '0;
         eraseCount <= '0;
      end else if (eraseHv) begin
         run <= run + 1'b1;
      end else if (run != '0) begin
         hvLen      <= run;
         lastPage   <= erasePage;
         eraseCount <= eraseCount + 1'b1;
         run        <= '0;
      end
   end
endmodule : flash_array_model
`default_nettype wire

// file: dv/flash_page_erase_sequencer_tb.sv
// Self-checking bench for the flash page erase sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_page_erase_sequencer_tb
   import flash_erase_pkg::*;
;
   // ==========================================
   // Signals
   localparam logic [CNT_W-1:0] SHORT_CYC = 20'h00032;
   localparam logic [CNT_W-1:0] LONG_CYC  = 20'h00064;
   logic             clk, rst, psel, penable, pwrite, pready, pslverr, eraseHv, err;
   logic [16:0]      paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic [8:0]       erasePage, lastPage;
   logic [7:0]       eraseCount;
   logic [1:0]       programRow;
   logic [CNT_W-1:0] hvLen;
   int               n_fail, total_checks, cyc;

   flash_page_erase_sequencer #(.ERASE_SHORT_CYC(SHORT_CYC), .ERASE_LONG_CYC(LONG_CYC))
      flash_page_erase_sequencer_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .eraseHv(eraseHv), .erasePage(erasePage), .programRow(programRow));
   flash_array_model flash_array_model_i (.clk(clk), .rst(rst), .eraseHv(eraseHv),
      .erasePage(erasePage), .hvLen(hvLen), .lastPage(lastPage), .eraseCount(eraseCount));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ==========================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   // One cycle of idle bus before each setup so no strobe is driven twice in a step
   task automatic apb(input logic w, input logic [16:0] a, input logic [31:0] d); // Bench code, no array fetch
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      cyc = 0;
      do begin
         @(posedge clk);
         cyc++;
      end while (pready !== 1'b1 && cyc < 1000);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (cyc >= 1000) begin
         n_fail++;
         $display("[FAIL] pready expected 1 seen timeout");
         wrap_up();
      end
   endtask : apb
   task automatic state(input logic [2:0] exp);
      apb(1'b0, {1'b0, STATUS_OFF}, 32'h0);
      check("state", rd[2:0], exp);
   endtask : state
   // ==========================================
   // Scenarios
   task automatic t_reset();
      apb(1'b0, {1'b0, CTRL_OFF}, 32'h0);
      check("ctrl reset", rd, 32'h0);
      apb(1'b0, {1'b0, STATUS_OFF}, 32'h0);
      check("status reset", rd, 32'h0);
      apb(1'b1, {1'b0, PROTECT_OFF}, 32'h0000_00a5);
      apb(1'b0, {1'b0, PROTECT_OFF}, 32'h0);
      check("protect rw", rd[7:0], 8'ha5);
      apb(1'b1, {1'b0, PAGE_OFF}, 32'hffff_ffff);
      apb(1'b0, {1'b0, PAGE_OFF}, 32'h0);
      check("page ro", rd, 32'h0);
      apb(1'b0, 17'h00010, 32'h0);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_erase();
      apb(1'b1, {1'b0, CTRL_OFF}, 32'h1);
      state(ST_MODE);
      apb(1'b0, {1'b0, PROTECT_OFF}, 32'h0);
      state(ST_PROT);
      apb(1'b1, 17'h12345, 32'hdead_beef);
      state(ST_LATCH);
      check("page port", erasePage, 9'h046);
      check("row port", programRow, 2'h1);
      repeat (SETUP_CYC + 10) @(posedge clk);
      apb(1'b1, {1'b0, CTRL_OFF}, 32'h5);
      repeat (2) @(posedge clk);
      check("hv on", eraseHv, 1'b1);
      repeat (SHORT_CYC + 10) @(posedge clk);
      apb(1'b1, {1'b0, CTRL_OFF}, 32'h4);
      state(ST_HOLD);
      check("hv in hold", eraseHv, 1'b1);
      repeat (HOLD_CYC + 10) @(posedge clk);
      apb(1'b1, {1'b0, CTRL_OFF}, 32'h0);
      apb(1'b0, 17'h12345, 32'h0);
      check("recovery stall", cyc > RECOVERY_CYC - 20, 1'b1);
      check("hv off", eraseHv, 1'b0);
      state(ST_IDLE);
      check("no flags", rd[11:8], 4'h0);
      check("erased page", lastPage, 9'h046);
      check("erase length", hvLen >= SHORT_CYC + HOLD_CYC, 1'b1);
      check("erase count", eraseCount, 8'h01);
      $display("test erase done");
   endtask : t_erase
   task automatic t_order();
      apb(1'b1, {1'b0, CTRL_OFF}, 32'h4);
      repeat (2) @(posedge clk);
      check("hv refused", eraseHv, 1'b0);
      check("no erase", eraseCount, 8'h01);
      state(ST_IDLE);
      check("order flag", rd[11:8], 4'h8);
      apb(1'b1, {1'b0, CTRL_OFF}, 32'h3);
      state(ST_IDLE);
      apb(1'b1, {1'b0, CTRL_OFF}, 32'h1);
      apb(1'b1, 17'h10080, 32'h0);
      state(ST_MODE);
      check("page kept", erasePage, 9'h046);
      apb(1'b1, {1'b0, CTRL_OFF}, 32'h0);
      state(ST_IDLE);
      apb(1'b1, {1'b0, STATUS_OFF}, 32'h0000_0f00);
      state(ST_IDLE);
      check("flags cleared", rd[11:8], 4'h0);
      $display("test order done");
   endtask : t_order
   // Long erase selected, setup, erase and hold waits cut short, last row of the last page
   task automatic t_breach();
      apb(1'b1, {1'b0, CTRL_OFF}, 32'h9);
      apb(1'b0, {1'b0, PROTECT_OFF}, 32'h0);
      apb(1'b1, 17'h1ffc0, 32'h0);
      // Page ports load at the answer edge itself, so look one cycle on
      @(posedge clk);
      check("last page", erasePage, 9'h1ff);
      check("last row", programRow, 2'h3);
      apb(1'b1, {1'b0, CTRL_OFF}, 32'hd);
      repeat (SHORT_CYC + 10) @(posedge clk);
      apb(1'b1, {1'b0, CTRL_OFF}, 32'hc);
      apb(1'b1, {1'b0, CTRL_OFF}, 32'h8);
      state(ST_RECOV);
      check("breach flags", rd[11:8], 4'h7);
      check("second erase", eraseCount, 8'h02);
      repeat (RECOVERY_CYC) @(posedge clk);
      apb(1'b1, {1'b0, STATUS_OFF}, 32'h0000_0f00);
      $display("test breach done");
   endtask : t_breach
   // ==========================================
   // Main sequence
   initial begin
      n_fail = 0;
      total_checks = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_erase(); // No interrupt source, nothing breaks into the sequence
      t_order();
      t_breach();
      wrap_up();
   end
endmodule : flash_page_erase_sequencer_tb
`default_nettype wire
